// ### core/ptpc_pkg.sv
// package: register map, field layout and constants of the pulse/capture timer
package ptpc_pkg;
  // register byte offsets on the apb bus
  localparam logic [11:0] PTPC_CTRL_OFS = 12'h000;
  localparam logic [11:0] PTPC_CMPA_OFS = 12'h004;
  localparam logic [11:0] PTPC_PERP_OFS = 12'h008;
  localparam logic [11:0] PTPC_CNT_OFS = 12'h00C;
  localparam logic [11:0] PTPC_STAT_OFS = 12'h010;
  // control register field positions
  localparam int PTPC_RUN_BIT = 0;
  localparam int PTPC_MODE_LO_BIT = 1;
  localparam int PTPC_MODE_HI_BIT = 2;
  localparam int PTPC_PINB_LO_BIT = 3;
  localparam int PTPC_PINB_HI_BIT = 4;
  localparam int PTPC_CAPS_BIT = 5;
  localparam int PTPC_CCLR_BIT = 6;
  localparam int PTPC_OINIT_BIT = 7;
  localparam int PTPC_OINV_BIT = 8;
  localparam int PTPC_CAPSEL_BIT = 9;
  localparam int PTPC_CTRL_W = 10;
  // status register field positions (write one to clear)
  localparam int PTPC_FLAG_A_BIT = 0;
  localparam int PTPC_FLAG_P_BIT = 1;
  // counter
  localparam int PTPC_CNT_W = 10;
  localparam logic [9:0] PTPC_CNT_MAX = 10'h3FF;
  localparam logic [9:0] PTPC_ZERO = 10'h000;
  localparam logic [9:0] PTPC_ONE = 10'h001;
  // mode field encodings
  localparam logic [1:0] PTPC_MODE_CAPTURE = 2'h1;
  localparam logic [1:0] PTPC_MODE_PULSE = 2'h2;
  localparam logic [1:0] PTPC_PINB_PULSE = 2'h3;
  localparam logic [1:0] PTPC_EDGE_RISE = 2'h0;
  localparam logic [1:0] PTPC_EDGE_FALL = 2'h1;
  localparam logic [1:0] PTPC_EDGE_BOTH = 2'h2;
  localparam logic [1:0] PTPC_EDGE_NONE = 2'h3;
  localparam logic [31:0] PTPC_RD_ZERO = 32'h0000_0000;
  // run-state enumeration, gray along idle -> running
  typedef enum logic [0:0] {PTPC_IDLE = 1'b0, PTPC_RUNNING = 1'b1} ptpc_state_t;
endpackage : ptpc_pkg

// ### core/ptpc_timer.sv
// module: one-shot pulse and input-capture timer with apb register slave
`timescale 1ns/1ps
// Behaviour
// - pulse mode: mode 10 with pins 11
// - run bit rise starts counter, and in pulse mode the pulse
// - pulse mode: ext clock edge sets run
// - run bit clear ends the pulse
// - pulse mode: match A clears run
// - pulse mode: match A raises flag A
// - pulse mode: count zeroed only at start
// - pulse mode ignores period and clear select
// - capture mode: mode field 01
// - source select picks capture or ext pins
// - pin field picks edge; 11 no capture
// - capture mode: run rise starts counting
// - active edge copies count, raises flag A
// - capture counter free runs until run falls
// - match P zeroes counter, raises flag P
// - period zero runs to full count
// - capture ignores clear bit; level, polarity only set idle output
// - capture never acts on output pins (pin field 11)
// - counter ten bits, max 3FF
module ptpc_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clock_pin_a,
  input wire logic ext_clock_pin_b,
  input wire logic capture_in_pin_a,
  input wire logic capture_in_pin_b,
  output logic timer_out,
  output logic match_a_flag,
  output logic match_p_flag
);
  import ptpc_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [ptpc_pkg::PTPC_CTRL_W-1:0] ctrl;
    logic [ptpc_pkg::PTPC_CNT_W-1:0] cmpa;
    logic [ptpc_pkg::PTPC_CNT_W-1:0] perp;
    logic [ptpc_pkg::PTPC_CNT_W-1:0] cnt;
    ptpc_pkg::ptpc_state_t st;
    logic flag_a;
    logic flag_p;
    logic out;
    logic [3:0] pin_d;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } ptpc_regs_t;

  ptpc_regs_t s_r;
  ptpc_regs_t s_nxt;

  // ==========================================================
  // decoded fields
  logic run;
  logic [1:0] mode;
  logic [1:0] pinb;
  logic pulse_mode;
  logic capt_mode;
  logic [3:0] pins;
  logic [3:0] rise;
  logic [3:0] fall;
  logic ext_edge;
  logic cap_edge_rise;
  logic cap_edge_fall;
  logic cap_hit;
  logic match_a;
  logic match_p;
  logic idle_lvl;
  logic acc;
  logic wr;

  assign run = s_r.ctrl[PTPC_RUN_BIT];
  assign mode = {s_r.ctrl[PTPC_MODE_HI_BIT], s_r.ctrl[PTPC_MODE_LO_BIT]};
  assign pinb = {s_r.ctrl[PTPC_PINB_HI_BIT], s_r.ctrl[PTPC_PINB_LO_BIT]};
  // both fields must agree before the one-shot engine is used
  assign pulse_mode = (mode == PTPC_MODE_PULSE) && (pinb == PTPC_PINB_PULSE);
  assign capt_mode = (mode == PTPC_MODE_CAPTURE);
  assign pins = {capture_in_pin_b, capture_in_pin_a, ext_clock_pin_b, ext_clock_pin_a};
  assign rise = pins & ~s_r.pin_d;
  assign fall = ~pins & s_r.pin_d;
  // pins are taken as synchronous; any direction counts as a trigger edge
  assign ext_edge = |(rise[1:0] | fall[1:0]);
  // source select: high takes dedicated capture pins, low the ext clock pins
  assign cap_edge_rise = s_r.ctrl[PTPC_CAPS_BIT] ? |rise[3:2] : |rise[1:0];
  assign cap_edge_fall = s_r.ctrl[PTPC_CAPS_BIT] ? |fall[3:2] : |fall[1:0];
  always_comb begin
    case (pinb)
      PTPC_EDGE_RISE: cap_hit = cap_edge_rise;
      PTPC_EDGE_FALL: cap_hit = cap_edge_fall;
      PTPC_EDGE_BOTH: cap_hit = cap_edge_rise | cap_edge_fall;
      default: cap_hit = 1'b0;
    endcase
  end
  assign match_a = (s_r.st == PTPC_RUNNING) && (s_r.cnt == s_r.cmpa);
  // period zero means no early match, so the count wraps past 3FF
  assign match_p = (s_r.st == PTPC_RUNNING) && (s_r.perp != PTPC_ZERO) && (s_r.cnt == s_r.perp);
  assign idle_lvl = s_r.ctrl[PTPC_OINIT_BIT] ^ s_r.ctrl[PTPC_OINV_BIT];
  assign acc = psel && penable;
  // a write lands only at the edge where pready is sampled high, so it lands once
  assign wr = acc && pwrite && s_r.ready;

  // ==========================================================
  // next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.pin_d = pins;
    s_nxt.ready = 1'b0;
    s_nxt.err = 1'b0;
    // register writes land first so hardware events below override them
    if (wr) begin
      case (paddr)
        PTPC_CTRL_OFS: s_nxt.ctrl = pwdata[PTPC_CTRL_W-1:0];
        PTPC_CMPA_OFS: s_nxt.cmpa = pwdata[PTPC_CNT_W-1:0];
        PTPC_PERP_OFS: s_nxt.perp = pwdata[PTPC_CNT_W-1:0];
        PTPC_STAT_OFS: begin
          if (pwdata[PTPC_FLAG_A_BIT]) s_nxt.flag_a = 1'b0;
          if (pwdata[PTPC_FLAG_P_BIT]) s_nxt.flag_p = 1'b0;
        end
        default: s_nxt.err = 1'b0;
      endcase
    end
    // one wait state; ready stands for one cycle only, so a held access never doubles
    if (acc && !s_r.ready) begin
      s_nxt.ready = 1'b1;
    end
    // trigger pin sets the run bit automatically
    if (pulse_mode && ext_edge) begin
      s_nxt.ctrl[PTPC_RUN_BIT] = 1'b1;
    end
    case (s_r.st)
      PTPC_IDLE: begin
        if (run) begin
          // counter restarts from zero here, and in capture mode also on match P
          s_nxt.st = PTPC_RUNNING;
          s_nxt.cnt = PTPC_ZERO;
          s_nxt.out = pulse_mode ? ~idle_lvl : idle_lvl;
        end else begin
          s_nxt.out = pulse_mode ? idle_lvl : s_r.out;
        end
      end
      PTPC_RUNNING: begin
        if (!run) begin
          // software clear ends pulse and halts counting, count is held
          s_nxt.st = PTPC_IDLE;
          s_nxt.out = idle_lvl;
        end else if (pulse_mode) begin
          // period and clear select deliberately unused here
          if (match_a) begin
            // count stops on the match value, so software can read back the width
            s_nxt.ctrl[PTPC_RUN_BIT] = 1'b0;
            s_nxt.st = PTPC_IDLE;
            s_nxt.out = idle_lvl;
            s_nxt.flag_a = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + PTPC_ONE;
          end
        end else if (capt_mode) begin
          // level and polarity bits not looked at in capture
          if (match_p) begin
            s_nxt.cnt = PTPC_ZERO;
            s_nxt.flag_p = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + PTPC_ONE;
          end
          if (cap_hit) begin
            s_nxt.cmpa = s_r.cnt;
            s_nxt.flag_a = 1'b1;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + PTPC_ONE;
        end
      end
      default: s_nxt.st = PTPC_IDLE;
    endcase
    // read data is registered in the access cycle
    s_nxt.rdata = PTPC_RD_ZERO;
    if (acc && !pwrite && !s_r.ready) begin
      case (paddr)
        PTPC_CTRL_OFS: s_nxt.rdata[PTPC_CTRL_W-1:0] = s_r.ctrl;
        PTPC_CMPA_OFS: s_nxt.rdata[PTPC_CNT_W-1:0] = s_r.cmpa;
        PTPC_PERP_OFS: s_nxt.rdata[PTPC_CNT_W-1:0] = s_r.perp;
        PTPC_CNT_OFS: s_nxt.rdata[PTPC_CNT_W-1:0] = s_r.cnt;
        PTPC_STAT_OFS: begin
          s_nxt.rdata[PTPC_FLAG_A_BIT] = s_r.flag_a;
          s_nxt.rdata[PTPC_FLAG_P_BIT] = s_r.flag_p;
        end
        default: s_nxt.rdata = PTPC_RD_ZERO;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign timer_out = s_r.out;
  assign match_a_flag = s_r.flag_a;
  assign match_p_flag = s_r.flag_p;

  // ==========================================================
  // checks
  sequence seq_start;
    (s_r.st == PTPC_IDLE) && run;
  endsequence
  sequence seq_zeroed;
    (s_r.st == PTPC_RUNNING) && (s_r.cnt == PTPC_ZERO);
  endsequence

  chk_start_zero: assert property (@(posedge pclk) disable iff (!presetn) seq_start |=> seq_zeroed)
    else $error("count not zero after start");
  chk_pulse_level: assert property (@(posedge pclk) disable iff (!presetn)
    seq_start and pulse_mode |=> timer_out == ~idle_lvl)
    else $error("pulse leading edge missing");
  chk_trig_run: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_mode && ext_edge |=> run)
    else $error("trigger did not set run");
  chk_match_a_stop: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_mode && run && match_a && !wr |=> !run && s_r.st == PTPC_IDLE && match_a_flag)
    else $error("match a did not end pulse");
  chk_idle_level: assert property (@(posedge pclk) disable iff (!presetn)
    $past(pulse_mode) && $past(s_r.st) == PTPC_IDLE && !$past(run) |-> timer_out == $past(idle_lvl))
    else $error("idle output level wrong");
  chk_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
    capt_mode && run && s_r.st == PTPC_RUNNING && cap_hit && !wr |=> s_r.cmpa == $past(s_r.cnt) && match_a_flag)
    else $error("capture did not latch count");
  chk_no_edge_sel: assert property (@(posedge pclk) disable iff (!presetn)
    capt_mode && pinb == PTPC_EDGE_NONE |-> !cap_hit)
    else $error("capture with edge select off");
  chk_period_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    capt_mode && run && match_p |=> s_r.cnt == PTPC_ZERO && match_p_flag)
    else $error("period match did not clear");
  chk_full_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    capt_mode && run && s_r.st == PTPC_RUNNING && s_r.perp == PTPC_ZERO && s_r.cnt == PTPC_CNT_MAX
    |=> s_r.cnt == PTPC_ZERO)
    else $error("counter did not wrap at max");
  chk_pulse_count: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_mode && run && s_r.st == PTPC_RUNNING && !match_a && !wr |=> s_r.cnt == $past(s_r.cnt) + PTPC_ONE)
    else $error("pulse counter not counting");
  chk_capture_runs: assert property (@(posedge pclk) disable iff (!presetn)
    capt_mode && run && s_r.st == PTPC_RUNNING && !match_p && !wr |=> s_r.cnt == $past(s_r.cnt) + PTPC_ONE)
    else $error("capture counter stalled");
  chk_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
endmodule : ptpc_timer

// ### verification/periodic_timer_pulse_capture_tb_top.sv
// testbench: apb-driven pulse and capture scenarios with read queue
`timescale 1ns/1ps
module periodic_timer_pulse_capture_tb_top;
  import ptpc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, timer_out, match_a_flag, match_p_flag;
  logic [3:0] tgl = 4'h0, pins;
  logic [31:0] q[$];
  logic [7:0] rnd = 8'h4C;
  logic [9:0] wa;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  // ====================
  // clock, timeout
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end
  ptpc_pin_model pm (.pclk(pclk), .presetn(presetn), .tgl(tgl), .pins(pins));
  ptpc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin_a(pins[0]), .ext_clock_pin_b(pins[1]), .capture_in_pin_a(pins[2]),
    .capture_in_pin_b(pins[3]), .timer_out(timer_out), .match_a_flag(match_a_flag),
    .match_p_flag(match_p_flag));
  // ====================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [31:0] cw(input logic r, input logic [1:0] m, input logic [1:0] p,
      input logic c, input logic o);
    cw = 32'h0;
    cw[PTPC_RUN_BIT] = r;
    cw[PTPC_MODE_HI_BIT:PTPC_MODE_LO_BIT] = m;
    cw[PTPC_PINB_HI_BIT:PTPC_PINB_LO_BIT] = p;
    cw[PTPC_CAPS_BIT] = c;
    cw[PTPC_OINIT_BIT] = o;
  endfunction : cw
  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge between transfers so psel is never driven twice in one step
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic pin(input int i);
    tgl <= 4'h1 << i;
    @(posedge pclk);
    tgl <= 4'h0;
    repeat (4) @(posedge pclk);
  endtask : pin
  task automatic wait_out(input logic v, input string what);
    int n;
    n = 0;
    while (timer_out !== v && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    check(timer_out, v, what);
  endtask : wait_out
  // read monitor: the oldest note is compared when read data appears
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) check(prdata, q.pop_front(), "prdata");
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // ====================
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(PTPC_CTRL_OFS, 32'h0);
    rd(12'h020, PTPC_RD_ZERO);
    rnd = lfsr(rnd);
    wa = {4'h0, rnd[5:0]} + 10'h002;
    apb(1'b1, PTPC_CMPA_OFS, {22'h0, wa});
    apb(1'b1, PTPC_CTRL_OFS, cw(0, PTPC_MODE_PULSE, PTPC_PINB_PULSE, 0, 0));
    check(timer_out, 1'b0, "idle out");
    apb(1'b1, PTPC_CTRL_OFS, cw(1, PTPC_MODE_PULSE, PTPC_PINB_PULSE, 0, 0));
    wait_out(1'b1, "lead");
    wait_out(1'b0, "trail");
    check(match_a_flag, 1'b1, "flag a");
    rd(PTPC_CTRL_OFS, cw(0, PTPC_MODE_PULSE, PTPC_PINB_PULSE, 0, 0));
    rd(PTPC_CNT_OFS, {22'h0, wa});
    $display("sw pulse done");
    apb(1'b1, PTPC_STAT_OFS, 32'h3);
    apb(1'b1, PTPC_PERP_OFS, 32'h1);
    pin(1);
    wait_out(1'b1, "ext lead");
    wait_out(1'b0, "ext trail");
    rd(PTPC_CNT_OFS, {22'h0, wa});
    apb(1'b1, PTPC_STAT_OFS, 32'h3);
    apb(1'b1, PTPC_CMPA_OFS, 32'h3FF);
    apb(1'b1, PTPC_CTRL_OFS, cw(1, PTPC_MODE_PULSE, PTPC_PINB_PULSE, 0, 0));
    wait_out(1'b1, "lead2");
    apb(1'b1, PTPC_CTRL_OFS, cw(0, PTPC_MODE_PULSE, PTPC_PINB_PULSE, 0, 0));
    wait_out(1'b0, "sw trail");
    check(match_a_flag, 1'b0, "no flag");
    apb(1'b1, PTPC_CTRL_OFS, cw(0, PTPC_MODE_PULSE, PTPC_PINB_PULSE, 0, 1));
    wait_out(1'b1, "idle high");
    $display("pulse done");
    // capture: every edge setting, rising then falling edge on the capture pin
    apb(1'b1, PTPC_PERP_OFS, 32'h0);
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, PTPC_CTRL_OFS, cw(1, PTPC_MODE_CAPTURE, e[1:0], 1, 0));
      apb(1'b1, PTPC_STAT_OFS, 32'h3);
      pin(2);
      check(match_a_flag, e == 0 || e == 2, "cap rise");
      apb(1'b1, PTPC_STAT_OFS, 32'h3);
      pin(2);
      check(match_a_flag, e == 1 || e == 2, "cap fall");
    end
    apb(1'b1, PTPC_CTRL_OFS, cw(1, PTPC_MODE_CAPTURE, PTPC_EDGE_RISE, 0, 0));
    apb(1'b1, PTPC_STAT_OFS, 32'h3);
    pin(2);
    check(match_a_flag, 1'b0, "src ignore");
    pin(0);
    check(match_a_flag, 1'b1, "src ext");
    apb(1'b1, PTPC_PERP_OFS, 32'h3);
    // restart from zero so the period match comes within a few cycles
    apb(1'b1, PTPC_CTRL_OFS, cw(0, PTPC_MODE_CAPTURE, PTPC_EDGE_RISE, 0, 0));
    apb(1'b1, PTPC_CTRL_OFS, cw(1, PTPC_MODE_CAPTURE, PTPC_EDGE_RISE, 0, 0));
    apb(1'b1, PTPC_STAT_OFS, 32'h3);
    repeat (20) @(posedge pclk);
    check(match_p_flag, 1'b1, "flag p");
    $display("capture done");
    wrap_up();
  end
endmodule : periodic_timer_pulse_capture_tb_top

// ### verification/ptpc_pin_model.sv
// pin model: drives trigger and capture pins of the timer
`timescale 1ns/1ps
module ptpc_pin_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] tgl,
  output logic [3:0] pins
);
  // ====================
  // pin levels
  // one toggle request gives exactly one edge, so each edge kind is chosen by the bench
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= 4'h0;
    end else begin
      pins <= pins ^ tgl;
    end
  end
endmodule : ptpc_pin_model
